// >>> verilog/own_addr_pkg.sv
// Constants for the own-address match block: register map, fields, resets.
// Assumes a 32-bit AXI4-Lite bus with byte addresses in the low eight bits.
package own_addr_pkg;
   localparam int          ADDR_W        = 8;
   localparam int          NUM_SLOTS     = 4;
   // Register byte offsets
   localparam logic [7:0]  SLOT0_OFF     = 8'h00;
   localparam logic [7:0]  SLOT_STEP     = 8'h04;
   localparam logic [7:0]  CTRL_OFF      = 8'h10;
   localparam logic [7:0]  MASK_OFF      = 8'h14;
   localparam logic [7:0]  RXADDR_OFF    = 8'h18;
   // Slot field positions
   localparam int          GCEN_BIT      = 15;
   localparam int          OAEN_BIT      = 10;
   localparam int          ADDR10_MSB    = 9;
   localparam int          ADDR7_MSB     = 6;
   // Writable bits of slot 0 and of slots 1 to 3
   localparam logic [15:0] SLOT0_WMASK   = 16'h87ff;
   localparam logic [15:0] SLOTN_WMASK   = 16'h07ff;
   // Control fields
   localparam int          HOLD_BIT      = 0;
   localparam int          TENBIT_BIT    = 1;
   // Reset values
   localparam logic [15:0] SLOT_RESET    = 16'h0000;
   localparam logic [9:0]  MASK_RESET    = 10'h3ff;
   localparam logic        HOLD_RESET    = 1'h1;
   // Compare widths
   localparam logic [9:0]  WIDTH7_MASK   = 10'h07f;
   localparam logic [9:0]  WIDTH10_MASK  = 10'h3ff;
   localparam logic [6:0]  GENERAL_CALL  = 7'h00;
   // Bus responses
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// >>> verilog/reg_req_if.sv
// Simple register request carrier between the bus slave and the register file.
// Assumes both ends run on the same clock; all signals are combinational.
`timescale 1ns/10ps
interface reg_req_if;
   logic        wr_en;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        wr_err;
   logic        rd_en;
   logic [7:0]  rd_addr;
   logic [31:0] rd_data;
   logic        rd_err;
   modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                input  wr_err, rd_data, rd_err);
   modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 output wr_err, rd_data, rd_err);
endinterface

// >>> verilog/slot_compare.sv
// One own-address slot comparator, purely combinational.
// Assumes the incoming address is right-justified like the slot value.
`timescale 1ns/10ps
module slot_compare (
   // Slot contents
   input  wire logic [9:0] slot_value,
   input  wire logic       slot_en,
   // Shared compare setup
   input  wire logic [9:0] care_mask,
   input  wire logic       ten_bit,
   input  wire logic [9:0] addr_in,
   // Result
   output      logic       hit
);
   import own_addr_pkg::*;
   logic [9:0] width_mask;

   // Width by mode, cleared mask bits are don't-care
   assign width_mask = ten_bit ? WIDTH10_MASK : WIDTH7_MASK;
   assign hit = slot_en && (((slot_value ^ addr_in) & care_mask & width_mask) == 10'h000);
endmodule

// >>> verilog/axil_slave.sv
// AXI4-Lite slave front end: turns bus traffic into single-cycle register requests.
// Assumes one outstanding write and one outstanding read; answers one cycle later.
`timescale 1ns/10ps
module axil_slave (
   // Clock and reset
   input  wire logic                            aclk,
   input  wire logic                            aresetn,
   // Write address and data
   input  wire logic [own_addr_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                            awvalid,
   output      logic                            awready,
   input  wire logic [31:0]                     wdata,
   input  wire logic [3:0]                      wstrb,
   input  wire logic                            wvalid,
   output      logic                            wready,
   // Write response
   output      logic [1:0]                      bresp,
   output      logic                            bvalid,
   input  wire logic                            bready,
   // Read
   input  wire logic [own_addr_pkg::ADDR_W-1:0] araddr,
   input  wire logic                            arvalid,
   output      logic                            arready,
   output      logic [31:0]                     rdata,
   output      logic [1:0]                      rresp,
   output      logic                            rvalid,
   input  wire logic                            rready,
   // Register side
   reg_req_if.bus                               req
);
   import own_addr_pkg::*;

   typedef struct packed {
      logic        aw_full;
      logic [7:0]  aw_addr;
      logic        w_full;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        aw_rdy;
      logic        w_rdy;
      logic        b_vld;
      logic [1:0]  b_resp;
      logic        ar_rdy;
      logic        r_vld;
      logic [31:0] r_data;
      logic [1:0]  r_resp;
   } axil_state_t;

   axil_state_t s_reg;
   axil_state_t s_next;
   logic        do_wr;
   logic        do_rd;

   // Write fires once address and data are both held
   assign do_wr        = s_reg.aw_full && s_reg.w_full && !s_reg.b_vld;
   assign do_rd        = s_reg.ar_rdy && arvalid;
   assign req.wr_en    = do_wr;
   assign req.wr_addr  = s_reg.aw_addr;
   assign req.wr_data  = s_reg.w_data;
   assign req.wr_strb  = s_reg.w_strb;
   assign req.rd_en    = do_rd;
   assign req.rd_addr  = araddr;

   // Channel bookkeeping
   always_comb begin
      s_next = s_reg;
      if (s_reg.aw_rdy && awvalid) begin
         s_next.aw_full = 1'b1;
         s_next.aw_addr = awaddr;
      end
      if (s_reg.w_rdy && wvalid) begin
         s_next.w_full = 1'b1;
         s_next.w_data = wdata;
         s_next.w_strb = wstrb;
      end
      if (s_reg.b_vld && bready) begin
         s_next.b_vld = 1'b0;
      end
      if (do_wr) begin
         s_next.aw_full = 1'b0;
         s_next.w_full  = 1'b0;
         s_next.b_vld   = 1'b1;
         s_next.b_resp  = req.wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_reg.r_vld && rready) begin
         s_next.r_vld = 1'b0;
      end
      if (do_rd) begin
         s_next.r_vld  = 1'b1;
         s_next.r_data = req.rd_data;
         s_next.r_resp = req.rd_err ? RESP_SLVERR : RESP_OKAY;
      end
      // Ready stays low while a response waits, so nothing queues up
      s_next.aw_rdy = !s_next.aw_full && !s_next.b_vld;
      s_next.w_rdy  = !s_next.w_full && !s_next.b_vld;
      s_next.ar_rdy = !s_next.r_vld;
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign awready = s_reg.aw_rdy;
   assign wready  = s_reg.w_rdy;
   assign bvalid  = s_reg.b_vld;
   assign bresp   = s_reg.b_resp;
   assign arready = s_reg.ar_rdy;
   assign rvalid  = s_reg.r_vld;
   assign rdata   = s_reg.r_data;
   assign rresp   = s_reg.r_resp;
endmodule

// >>> verilog/own_addr_match.sv
// Own-address configuration and target address matching for an I2C target.
// Assumes the I2C engine on the same clock presents each received address as
// a one-cycle strobe, and software reaches the registers over AXI4-Lite.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module own_addr_match (
   // Clock and reset
   input  wire logic                            aclk,
   input  wire logic                            aresetn,
   // AXI4-Lite write address and data
   input  wire logic [own_addr_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                            awvalid,
   output      logic                            awready,
   input  wire logic [31:0]                     wdata,
   input  wire logic [3:0]                      wstrb,
   input  wire logic                            wvalid,
   output      logic                            wready,
   // AXI4-Lite write response
   output      logic [1:0]                      bresp,
   output      logic                            bvalid,
   input  wire logic                            bready,
   // AXI4-Lite read
   input  wire logic [own_addr_pkg::ADDR_W-1:0] araddr,
   input  wire logic                            arvalid,
   output      logic                            arready,
   output      logic [31:0]                     rdata,
   output      logic [1:0]                      rresp,
   output      logic                            rvalid,
   input  wire logic                            rready,
   // Received address from the I2C engine
   input  wire logic                            addr_valid,
   input  wire logic [9:0]                      addr_in,
   // Match result, hold and mode state
   output      logic                            addr_ack,
   output      logic                            addr_nack,
   output      logic                            general_call_ack,
   output      logic [1:0]                      matched_slot,
   output      logic                            soft_reset_hold,
   output      logic                            ten_bit_mode
);
   import own_addr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic [NUM_SLOTS-1:0][15:0] slot;
      logic                       hold;
      logic                       ten_bit;
      logic [9:0]                 mask;
      logic [9:0]                 rx_addr;
      logic                       ack;
      logic                       nack;
      logic                       gc_ack;
      logic [1:0]                 slot_idx;
   } match_state_t;

   match_state_t         s_reg;
   match_state_t         s_next;
   reg_req_if            req ();
   logic [NUM_SLOTS-1:0] hit;
   logic                 is_gc;
   logic [31:0]          byte_mask;

   ////////////////////////////////////////////////////////////////////////////
   // Bus front end

   axil_slave u_bus (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .req     (req.bus)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Slot comparators, one per slot

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
         slot_compare u_cmp (
            .slot_value (s_reg.slot[gi][ADDR10_MSB:0]),
            .slot_en    (s_reg.slot[gi][OAEN_BIT]),
            .care_mask  (s_reg.mask),
            .ten_bit    (s_reg.ten_bit),
            .addr_in    (addr_in),
            .hit        (hit[gi])
         );
      end
   endgenerate

   // General call is the all-zero seven-bit address
   assign is_gc = !s_reg.ten_bit && (addr_in[ADDR7_MSB:0] == GENERAL_CALL);

   // Byte lanes to bit mask
   assign byte_mask = {{8{req.wr_strb[3]}}, {8{req.wr_strb[2]}},
                       {8{req.wr_strb[1]}}, {8{req.wr_strb[0]}}};

   ////////////////////////////////////////////////////////////////////////////
   // Register read decode

   always_comb begin
      req.rd_data = 32'h0000_0000;
      req.rd_err  = 1'b0;
      case (req.rd_addr)
         SLOT0_OFF,
         SLOT0_OFF + SLOT_STEP,
         SLOT0_OFF + 8'h02 * SLOT_STEP,
         SLOT0_OFF + 8'h03 * SLOT_STEP: begin
            // Reserved bits are never stored, so they read zero
            req.rd_data = {16'h0000, s_reg.slot[req.rd_addr[3:2]]};
         end
         CTRL_OFF: begin
            req.rd_data[HOLD_BIT]   = s_reg.hold;
            req.rd_data[TENBIT_BIT] = s_reg.ten_bit;
         end
         MASK_OFF: begin
            req.rd_data = {22'h000000, s_reg.mask};
         end
         RXADDR_OFF: begin
            req.rd_data = {22'h000000, s_reg.rx_addr};
         end
         default: begin
            req.rd_err = 1'b1;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes and address matching

   always_comb begin
      s_next        = s_reg;
      req.wr_err    = 1'b0;
      s_next.ack    = 1'b0;
      s_next.nack   = 1'b0;
      s_next.gc_ack = 1'b0;
      if (req.wr_en) begin
         case (req.wr_addr)
            SLOT0_OFF,
            SLOT0_OFF + SLOT_STEP,
            SLOT0_OFF + 8'h02 * SLOT_STEP,
            SLOT0_OFF + 8'h03 * SLOT_STEP: begin
               // Writes outside the hold window are dropped, not errors
               if (s_reg.hold) begin
                  for (int i = 0; i < NUM_SLOTS; i++) begin
                     if (req.wr_addr[3:2] == 2'(i)) begin
                        s_next.slot[i] = (s_reg.slot[i] & ~byte_mask[15:0])
                                       | (req.wr_data[15:0] & byte_mask[15:0]
                                          & (i == 0 ? SLOT0_WMASK : SLOTN_WMASK));
                     end
                  end
               end
            end
            CTRL_OFF: begin
               if (req.wr_strb[0]) begin
                  s_next.hold    = req.wr_data[HOLD_BIT];
                  s_next.ten_bit = req.wr_data[TENBIT_BIT];
               end
            end
            MASK_OFF: begin
               if (s_reg.hold) begin
                  s_next.mask = (s_reg.mask & ~byte_mask[9:0])
                              | (req.wr_data[9:0] & byte_mask[9:0]);
               end
            end
            RXADDR_OFF: begin
               // Read-only, write ignored
            end
            default: begin
               req.wr_err = 1'b1;
            end
         endcase
      end
      // Matching is off while software holds the block in reset
      if (addr_valid && !s_reg.hold) begin
         if (is_gc) begin
            s_next.gc_ack = s_reg.slot[0][GCEN_BIT];
            s_next.ack    = s_reg.slot[0][GCEN_BIT];
            s_next.nack   = !s_reg.slot[0][GCEN_BIT];
         end else begin
            s_next.ack  = |hit;
            s_next.nack = ~|hit;
            // Lowest-numbered matching slot is reported
            for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
               if (hit[i]) begin
                  s_next.slot_idx = 2'(i);
               end
            end
         end
         if (s_next.ack) begin
            s_next.rx_addr = addr_in;
         end
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg         <= '0;
         s_reg.slot    <= {NUM_SLOTS{SLOT_RESET}};
         s_reg.mask    <= MASK_RESET;
         s_reg.hold    <= HOLD_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign addr_ack         = s_reg.ack;
   assign addr_nack        = s_reg.nack;
   assign general_call_ack = s_reg.gc_ack;
   assign matched_slot     = s_reg.slot_idx;
   assign soft_reset_hold  = s_reg.hold;
   assign ten_bit_mode     = s_reg.ten_bit;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence gc_seen;
      addr_valid && !s_reg.hold && !s_reg.ten_bit && addr_in[6:0] == 7'h00;
   endsequence

   sequence seven_hit_slot2;
      addr_valid && !s_reg.hold && !s_reg.ten_bit && s_reg.slot[2][10]
      && s_reg.mask == 10'h3ff && addr_in[6:0] != 7'h00
      && addr_in[6:0] == s_reg.slot[2][6:0];
   endsequence

   sequence addr_taken;
      addr_valid && !s_reg.hold;
   endsequence

   sequence one_answer;
      addr_ack ^ addr_nack;
   endsequence

   a_gc_ignored: assert property (
      gc_seen ##0 !s_reg.slot[0][15] |=> !addr_ack && addr_nack)
      else $error("general call acknowledged while disabled");
   a_gc_answered: assert property (
      gc_seen ##0 s_reg.slot[0][15] |=> general_call_ack && addr_ack)
      else $error("general call not acknowledged while enabled");
   a_upper_reserved: assert property (
      s_reg.slot[1][14:11] == 4'h0 && s_reg.slot[3][15:11] == 5'h00)
      else $error("reserved slot bits became set");
   a_disabled_slot: assert property (!s_reg.slot[2][10] |-> !hit[2])
      else $error("disabled slot produced a hit");
   a_seven_bit_hit: assert property (
      seven_hit_slot2 |=> addr_ack ##0 $past(addr_in) == s_reg.rx_addr)
      else $error("seven-bit match missed or address not kept");
   a_hold_locks: assert property (
      !s_reg.hold |=> $stable(s_reg.slot) && $stable(s_reg.mask))
      else $error("slot changed outside the hold window");
   a_reset_values: assert property (
      $rose(aresetn) |-> s_reg.slot == '0 && s_reg.mask == 10'h3ff)
      else $error("wrong value after reset");
   a_ack_cause: assert property (
      addr_ack |-> $past(addr_valid) && !$past(s_reg.hold))
      else $error("acknowledge without a received address");
   a_ten_bit_all: assert property (
      s_reg.ten_bit && s_reg.slot[0][10] && s_reg.mask == 10'h3ff
      && addr_in != s_reg.slot[0][9:0] |-> !hit[0])
      else $error("ten-bit compare ignored some bits");

   // One answer per taken address, none while held
   a_one_answer: assert property (addr_taken |=> one_answer)
      else $error("taken address not answered once");
   a_hold_no_answer: assert property (
      addr_valid && s_reg.hold |=> !addr_ack && !addr_nack)
      else $error("address answered during hold");
   a_nack_cause: assert property (
      addr_nack |-> $past(addr_valid) && !$past(s_reg.hold))
      else $error("refusal without an address");

   // General call only beside an acknowledge, never in ten-bit mode
   a_gc_with_ack: assert property (general_call_ack |-> addr_ack)
      else $error("general call without acknowledge");
   a_wide_no_gc: assert property (
      addr_taken ##0 s_reg.ten_bit |=> !general_call_ack)
      else $error("general call in ten-bit mode");

   // Capture follows acknowledged addresses only
   a_rx_only_ack: assert property (
      !addr_ack && $past(aresetn) |-> $stable(s_reg.rx_addr))
      else $error("capture changed without acknowledge");
   a_rx_takes_addr: assert property (
      addr_taken ##1 addr_ack |-> s_reg.rx_addr == $past(addr_in))
      else $error("capture differs from address");

   // Control word and capture after reset
   a_ctrl_reset: assert property (
      $rose(aresetn) |-> s_reg.hold && !s_reg.ten_bit && s_reg.rx_addr == 10'h000)
      else $error("control or capture wrong after reset");

   // Seven-bit compare ignores the upper bits; reserved bits of slots 0 and 2 stay zero
   a_upper_ignored: assert property (
      !s_reg.ten_bit && s_reg.slot[0][10] && s_reg.mask == 10'h3ff
      && addr_in[6:0] == s_reg.slot[0][6:0] |-> hit[0])
      else $error("seven-bit compare used upper bits");
   a_reserved_zero: assert property (
      s_reg.slot[0][14:11] == 4'h0 && s_reg.slot[2][15:11] == 5'h00)
      else $error("reserved bits of slot 0 or 2 set");

   // Cleared mask bits never block a match
   a_mask_dont_care: assert property (
      s_reg.slot[0][10] && ((s_reg.slot[0][9:0] ^ addr_in) & s_reg.mask) == 10'h000
      |-> hit[0])
      else $error("masked bit blocked a match");

   // Reported slot is the lowest one that matched
   a_lowest_slot: assert property (
      addr_taken ##0 !is_gc && hit[0] |=> matched_slot == 2'h0)
      else $error("slot 0 match not reported");
   a_slot3_hit: assert property (
      addr_taken ##0 !is_gc && hit == 4'b1000 |=> addr_ack && matched_slot == 2'h3)
      else $error("slot 3 match not reported");
endmodule

// >>> verification/addr_source.sv
// Behavioural I2C controller that presents received target addresses.
// Assumes the target answers one cycle after the strobe edge, on aclk.
`timescale 1ns/10ps
module addr_source (
   // Clock
   input  wire logic       aclk,
   // Answer from the target
   input  wire logic       addr_ack,
   input  wire logic       addr_nack,
   input  wire logic       general_call_ack,
   input  wire logic [1:0] matched_slot,
   // Address toward the target
   output      logic       addr_valid,
   output      logic [9:0] addr_in
);
   ////////////////////////////////////////////////////////////////////////////
   // Idle lines start on a pattern, never a handy zero
   initial begin
      addr_valid = 1'b0;
      addr_in    = 10'h2aa;
   end

   // One strobe, then the line is scrambled so stale data cannot match
   task automatic send(input logic [9:0] a, output logic [2:0] res, output logic [1:0] sl);
      @(posedge aclk);
      addr_valid <= 1'b1;
      addr_in    <= a;  // Right-justified address
      @(posedge aclk);
      addr_valid <= 1'b0;
      addr_in    <= ~a;
      #1;
      res = {addr_ack, addr_nack, general_call_ack};
      sl  = matched_slot;
   endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the own-address match block.
// Assumes AXI4-Lite register access and the address source model.
`timescale 1ns/10ps
module tb_top;
   import own_addr_pkg::*;
   logic        aclk;
   logic        aresetn;
   logic [7:0]  awaddr;
   logic        awvalid;
   logic        awready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [7:0]  araddr;
   logic        arvalid;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   logic        addr_valid;
   logic [9:0]  addr_in;
   logic        addr_ack;
   logic        addr_nack;
   logic        general_call_ack;
   logic [1:0]  matched_slot;
   logic        soft_reset_hold;
   logic        ten_bit_mode;
   int          err_count;
   int          checks_done;
   logic [1:0]  rs;

   own_addr_match own_addr_match_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .addr_valid(addr_valid), .addr_in(addr_in), .addr_ack(addr_ack),
      .addr_nack(addr_nack), .general_call_ack(general_call_ack),
      .matched_slot(matched_slot), .soft_reset_hold(soft_reset_hold),
      .ten_bit_mode(ten_bit_mode));

   addr_source addr_source_i (.aclk(aclk), .addr_ack(addr_ack), .addr_nack(addr_nack),
      .general_call_ack(general_call_ack), .matched_slot(matched_slot),
      .addr_valid(addr_valid), .addr_in(addr_in));

   ////////////////////////////////////////////////////////////////////////////
   // 20 MHz clock
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #(50 * 20000);
      err_count++;
      end_sim();
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      if (err_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [7:0] slot(input int i);
      return SLOT0_OFF + 8'(i) * SLOT_STEP;
   endfunction

   // Write: both channels offered together, each dropped once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= 4'hf;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      r = bresp;
      bready <= 1'b0;
   endtask

   // Read and compare data and response
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      chk(rdata, exp, "read data");
      chk(32'(rresp), 32'(er), "read response");
      rready <= 1'b0;
   endtask

   // Program slots and mask under hold, then set the control word
   task automatic cfg(input logic [15:0] s0, s1, s2, s3, input logic [9:0] mk,
                      input logic [1:0] c);
      logic [15:0] v[4];
      v = '{s0, s1, s2, s3};
      axw(CTRL_OFF, 32'h1, rs);  // Hold set before any change
      for (int i = 0; i < 4; i++) axw(slot(i), 32'(v[i]), rs);
      axw(MASK_OFF, 32'(mk), rs);
      axw(CTRL_OFF, 32'(c), rs);
   endtask

   // Offer one address; exp is {ack, nack, general call}
   task automatic m(input logic [9:0] a, input logic [2:0] exp, input logic [1:0] sl);
      logic [2:0] got;
      logic [1:0] s;
      addr_source_i.send(a, got, s);
      chk(32'(got), 32'(exp), "ack nack gc");
      if (exp == 3'b100) chk(32'(s), 32'(sl), "matched slot");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
      err_count   = 0;
      checks_done = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 4; i++) rdchk(slot(i), 32'h0, RESP_OKAY);
      rdchk(CTRL_OFF, 32'h1, RESP_OKAY);
      rdchk(MASK_OFF, 32'(MASK_RESET), RESP_OKAY);
      rdchk(RXADDR_OFF, 32'h0, RESP_OKAY);
      rdchk(8'h20, 32'h0, RESP_SLVERR);
      axw(8'h20, 32'hffff_ffff, rs);
      chk(32'(rs), 32'(RESP_SLVERR), "unmapped write");
      m(10'h000, 3'b000, 2'h0);
      // Reserved upper bits stay zero; gc enable only in slot 0
      for (int i = 0; i < 4; i++) begin
         axw(slot(i), 32'hffff_ffff, rs);
         rdchk(slot(i), 32'(i == 0 ? SLOT0_WMASK : SLOTN_WMASK), RESP_OKAY);
      end
      // Seven-bit mode; slot 1 disabled, slot 2 has junk in bits 9:7
      cfg(16'h0412, 16'h0055, 16'h07a5, 16'h0433, 10'h3ff, 2'b00);
      chk(32'(soft_reset_hold), 32'h0, "hold bit");
      axw(slot(1), 32'h0455, rs);
      chk(32'(rs), 32'(RESP_OKAY), "dropped write");
      rdchk(slot(1), 32'h0055, RESP_OKAY);
      m(10'h012, 3'b100, 2'h0);
      m(10'h055, 3'b010, 2'h0);
      m(10'h025, 3'b100, 2'h2);
      m(10'h312, 3'b100, 2'h0);
      m(10'h033, 3'b100, 2'h3);
      rdchk(RXADDR_OFF, 32'h033, RESP_OKAY);
      m(10'h000, 3'b010, 2'h0);
      // General call enabled, bit 0 don't-care
      cfg(16'h8412, 16'h0055, 16'h07a5, 16'h0433, 10'h3fe, 2'b00);
      m(10'h000, 3'b101, 2'h0);
      m(10'h013, 3'b100, 2'h0);
      m(10'h054, 3'b010, 2'h0);
      // Ten-bit mode
      cfg(16'h8412, 16'h0055, 16'h07a5, 16'h0433, 10'h3ff, 2'b10);
      chk(32'(ten_bit_mode), 32'h1, "mode bit");
      m(10'h3a5, 3'b100, 2'h2);
      m(10'h025, 3'b010, 2'h0);
      m(10'h012, 3'b100, 2'h0);
      m(10'h000, 3'b010, 2'h0);
      // Second reset in mid-run clears the slots again
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rdchk(slot(0), 32'h0, RESP_OKAY);
      rdchk(slot(2), 32'h0, RESP_OKAY);
      end_sim();
   end
endmodule
